/* File: src/fsps_pkg.sv */
package fsps_pkg;
  // register byte offsets on the 32-bit bus
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_UNLOCK = 8'h04;
  localparam logic [7:0] OFS_LATCH = 8'h08;
  localparam logic [7:0] OFS_POINTER = 8'h0C;
  localparam logic [7:0] OFS_TABLE_OP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // flash control register field positions
  localparam int BIT_START = 1;
  localparam int BIT_WRITE_ENABLE_BIT = 2;
  localparam int BIT_ERROR = 3;
  localparam int BIT_ERASE = 4;
  localparam int BIT_WORD_PROGRAM_BIT = 5;
  // table op command field positions
  localparam int BIT_OP_WRITE = 4;
  // unlock keys, in the order they must arrive
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  // reset values
  localparam logic [21:0] POINTER_RESET = 22'h000000;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  // pointer and array geometry
  localparam int PTR_W = 22;
  localparam int HOLD_DEPTH = 64;
  localparam int HOLD_IDX_W = 6;
  localparam logic [4:0] LAST_WORD = 5'h1F;
  // long write duration, arbitrary default, and the core clock rate
  localparam int TIW_US = 1000;
  localparam int CLK_MHZ = 50;
  localparam int TIW_CYCLES = TIW_US * CLK_MHZ;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pointer adjustment variants of a table op
  typedef enum logic [1:0] {
    PTR_KEEP = 2'b00,
    PTR_POSTINC = 2'b01,
    PTR_POSTDEC = 2'b10,
    PTR_PREINC = 2'b11
  } fsps_ptr_mode_type;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TRD = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG = 3'b011,
    ST_TIMER = 3'b100
  } fsps_state_type;

  // unlock progress
  typedef enum logic [1:0] {
    UL_NONE = 2'b00,
    UL_KEY1 = 2'b01,
    UL_OPEN = 2'b10
  } fsps_unlock_type;
endpackage

/* File: src/fsps_holding_bank.sv */
`timescale 1ns/1ps
module fsps_holding_bank #(
  parameter int DEPTH = fsps_pkg::HOLD_DEPTH,
  parameter int IDX_W = fsps_pkg::HOLD_IDX_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [IDX_W-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [IDX_W-2:0] rword_idx,
  output logic [15:0] rword
);
  import fsps_pkg::*;

  // byte-wide staging storage; deliberately not cleared by any reset
  logic [7:0] mem [DEPTH];

  // short write: only the staging byte changes, never the array
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // word view for programming, odd byte high
  assign rword = {mem[{rword_idx, 1'b1}], mem[{rword_idx, 1'b0}]};

  // a table write lands in the addressed staging byte; bytes start unknown, so only written ones are judged
  property p_hold_store;
    @(posedge aclk) disable iff (!aresetn)
      we |=> mem[$past(waddr)] == $past(wdata);
  endproperty
  a_hold_store: assert property (p_hold_store) else $error("holding byte not stored by table write");
endmodule

/* File: src/fsps_sequencer.sv */
`timescale 1ns/1ps
module fsps_sequencer #(
  parameter int LONG_WRITE_CYCLES = fsps_pkg::TIW_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_rst_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash array, word addressed
  output logic [20:0] flash_addr,
  output logic flash_rd_en,
  input wire logic [15:0] flash_rdata,
  output logic flash_prog_en,
  output logic [15:0] flash_wdata,
  output logic flash_erase_en,
  // core halt while a long write runs
  output logic cpu_stall
);
  import fsps_pkg::*;

  localparam int TMR_W = $clog2(LONG_WRITE_CYCLES + 1);

  fsps_state_type state_reg, state_next;
  fsps_unlock_type unlock_reg; // unlock key progress
  logic [PTR_W-1:0] ptr_reg; // table pointer
  logic [7:0] latch_reg; // table latch
  logic word_program_bit_reg, erase_reg, err_reg, write_enable_bit_reg, start_reg; // control bits
  logic [TMR_W-1:0] timer_reg; // long write timer
  logic [4:0] word_idx_reg; // word being programmed
  logic [15:0] hold_word; // holding word for word_idx
  logic [20:0] flash_addr_reg;
  logic flash_rd_en_reg, flash_prog_en_reg, flash_erase_en_reg, cpu_stall_reg;
  logic [15:0] flash_wdata_reg;
  logic flash_addr_sel_reg; // byte select of the read in flight
  // axi staging
  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;

  // adjust only the low 21 pointer bits; the top bit never moves
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic down);
    logic [20:0] low;
    low = down ? p[20:0] - 21'h1 : p[20:0] + 21'h1;
    return {p[21], low};
  endfunction

  // known register offsets
  function automatic logic mapped(input logic [7:0] a);
    return a == OFS_CONTROL || a == OFS_UNLOCK || a == OFS_LATCH || a == OFS_POINTER ||
           a == OFS_TABLE_OP || a == OFS_STATUS;
  endfunction

  // a register write fires when address and data are both held
  logic wr_fire, long_busy;
  logic ctl_wr, unlock_wr, latch_wr, ptr_wr, op_wr;
  logic start_req, start_ok, op_go;
  fsps_ptr_mode_type op_mode;
  logic [PTR_W-1:0] op_addr;

  // writes are held off while a long write runs, which stalls the core
  assign long_busy = state_reg == ST_ERASE || state_reg == ST_PROG || state_reg == ST_TIMER;
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg && !long_busy;
  assign ctl_wr = wr_fire && awaddr_reg == OFS_CONTROL && wstrb_reg[0];
  assign unlock_wr = wr_fire && awaddr_reg == OFS_UNLOCK && wstrb_reg[0];
  assign latch_wr = wr_fire && awaddr_reg == OFS_LATCH && wstrb_reg[0];
  assign ptr_wr = wr_fire && awaddr_reg == OFS_POINTER;
  assign op_wr = wr_fire && awaddr_reg == OFS_TABLE_OP && wstrb_reg[0];
  // table ops run only from idle, so one op at a time
  assign op_go = op_wr && state_reg == ST_IDLE;
  assign op_mode = fsps_ptr_mode_type'(wdata_reg[1:0]);
  // pre-increment addresses the next byte, the rest the current one
  assign op_addr = op_mode == PTR_PREINC ? ptr_step(ptr_reg, 1'b0) : ptr_reg;
  // start needs the two keys just before it and write enable set
  assign start_req = ctl_wr && wdata_reg[BIT_START] && !start_reg;
  assign start_ok = start_req && unlock_reg == UL_OPEN && write_enable_bit_reg;

  // axi write channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // response only after both halves are in
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // axi read channel, status stays readable during a long write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= mapped({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      unique case ({s_axi_araddr[7:2], 2'b00})
        OFS_CONTROL: rdata_reg <= {26'h0, word_program_bit_reg, erase_reg, err_reg, write_enable_bit_reg, start_reg, 1'b0};
        OFS_LATCH: rdata_reg <= {24'h0, latch_reg};
        OFS_POINTER: rdata_reg <= {10'h0, ptr_reg};
        OFS_STATUS: rdata_reg <= {27'h0, state_reg, long_busy, unlock_reg == UL_OPEN};
        // unlock and op registers are write-only and read zero
        default: rdata_reg <= 32'h00000000;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // unlock tracker: any other write breaks the sequence
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_rst_n) begin
      unlock_reg <= UL_NONE;
    end else if (unlock_wr) begin
      if (wdata_reg[7:0] == UNLOCK_KEY2 && unlock_reg == UL_KEY1) begin
        unlock_reg <= UL_OPEN;
      end else if (wdata_reg[7:0] == UNLOCK_KEY1) begin
        unlock_reg <= UL_KEY1;
      end else begin
        unlock_reg <= UL_NONE;
      end
    end else if (wr_fire) begin
      unlock_reg <= UL_NONE;
    end
  end

  // control bits; hardware events beat a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_program_bit_reg <= 1'b0;
      erase_reg <= 1'b0;
      err_reg <= 1'b0;
      write_enable_bit_reg <= 1'b0;
      start_reg <= 1'b0;
    end else if (!core_rst_n) begin
      // a core reset mid-write leaves the error flag standing for software
      err_reg <= err_reg || start_reg;
      word_program_bit_reg <= 1'b0;
      erase_reg <= 1'b0;
      write_enable_bit_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      if (ctl_wr) begin
        word_program_bit_reg <= wdata_reg[BIT_WORD_PROGRAM_BIT];
        erase_reg <= wdata_reg[BIT_ERASE];
        write_enable_bit_reg <= wdata_reg[BIT_WRITE_ENABLE_BIT];
        err_reg <= wdata_reg[BIT_ERROR];
      end
      if (start_ok) begin
        start_reg <= 1'b1;
        err_reg <= 1'b1; // stays set if the write never completes
      end else if (start_req) begin
        err_reg <= 1'b1; // improper attempt
      end
      if (state_reg == ST_TIMER && timer_reg == TMR_W'(LONG_WRITE_CYCLES - 1)) begin
        // only completion or either reset clears start; software can only set it
        start_reg <= 1'b0;
        err_reg <= 1'b0;
        if (erase_reg) begin
          erase_reg <= 1'b0;
        end
      end
    end
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_ok && erase_reg) begin
          state_next = ST_ERASE;
        end else if (start_ok) begin
          state_next = ST_PROG;
        end else if (op_go && !wdata_reg[BIT_OP_WRITE]) begin
          state_next = ST_TRD;
        end
      end
      ST_TRD: state_next = ST_IDLE;
      ST_ERASE: state_next = ST_TIMER;
      // one word when word-program is set, else the 32 words of a row
      ST_PROG: begin
        if (word_program_bit_reg || word_idx_reg == LAST_WORD) begin
          state_next = ST_TIMER;
        end
      end
      ST_TIMER: begin
        if (timer_reg == TMR_W'(LONG_WRITE_CYCLES - 1)) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // state register and stall; a core reset aborts the long write
  always_ff @(posedge aclk) begin
    if (!aresetn || !core_rst_n) begin
      state_reg <= ST_IDLE;
      cpu_stall_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cpu_stall_reg <= state_next == ST_ERASE || state_next == ST_PROG || state_next == ST_TIMER;
    end
  end

  // long write timer, free of any software control
  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg != ST_TIMER) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_reg + TMR_W'(1);
    end
  end

  // word walker for programming
  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg != ST_PROG) begin
      word_idx_reg <= word_program_bit_reg ? ptr_reg[5:1] : 5'h00;
    end else begin
      word_idx_reg <= word_idx_reg + 5'h01;
    end
  end

  // table pointer: software writes per byte lane, table ops adjust it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_reg <= POINTER_RESET;
    end else if (ptr_wr) begin
      if (wstrb_reg[0]) ptr_reg[7:0] <= wdata_reg[7:0];
      if (wstrb_reg[1]) ptr_reg[15:8] <= wdata_reg[15:8];
      if (wstrb_reg[2]) ptr_reg[21:16] <= wdata_reg[21:16];
    end else if (op_go) begin
      unique case (op_mode)
        PTR_POSTINC, PTR_PREINC: ptr_reg <= ptr_step(ptr_reg, 1'b0);
        PTR_POSTDEC: ptr_reg <= ptr_step(ptr_reg, 1'b1);
        PTR_KEEP: ptr_reg <= ptr_reg;
      endcase
    end
  end

  // table latch: software write or the byte of a table read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= LATCH_RESET;
    end else if (state_reg == ST_TRD) begin
      // address bit zero set picks the high byte
      latch_reg <= flash_addr_sel_reg ? flash_rdata[15:8] : flash_rdata[7:0];
    end else if (latch_wr) begin
      latch_reg <= wdata_reg[7:0];
    end
  end

  // remembered byte select of the read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_addr_sel_reg <= 1'b0;
    end else if (op_go) begin
      flash_addr_sel_reg <= op_addr[0];
    end
  end

  // flash array strobes, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_addr_reg <= 21'h000000;
      flash_rd_en_reg <= 1'b0;
      flash_prog_en_reg <= 1'b0;
      flash_erase_en_reg <= 1'b0;
      flash_wdata_reg <= 16'h0000;
    end else begin
      flash_rd_en_reg <= 1'b0;
      flash_prog_en_reg <= 1'b0;
      flash_erase_en_reg <= 1'b0;
      if (op_go && !wdata_reg[BIT_OP_WRITE]) begin
        flash_rd_en_reg <= 1'b1;
        flash_addr_reg <= op_addr[21:1];
      end else if (state_reg == ST_ERASE) begin
        // whole block only, the low pointer bits are dropped
        flash_erase_en_reg <= 1'b1;
        flash_addr_reg <= {ptr_reg[21:10], 9'h000};
      end else if (state_reg == ST_PROG) begin
        flash_prog_en_reg <= 1'b1;
        flash_addr_reg <= {ptr_reg[21:6], word_idx_reg};
        flash_wdata_reg <= hold_word;
      end
    end
  end

  // 64 staging bytes, filled by table writes at pointer bits 5:0
  fsps_holding_bank #(
    .DEPTH(HOLD_DEPTH),
    .IDX_W(HOLD_IDX_W)
  ) u_hold (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(op_go && wdata_reg[BIT_OP_WRITE]),
    .waddr(op_addr[5:0]),
    .wdata(latch_reg),
    .rword_idx(word_idx_reg),
    .rword(hold_word)
  );

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign flash_addr = flash_addr_reg;
  assign flash_rd_en = flash_rd_en_reg;
  assign flash_prog_en = flash_prog_en_reg;
  assign flash_wdata = flash_wdata_reg;
  assign flash_erase_en = flash_erase_en_reg;
  assign cpu_stall = cpu_stall_reg;

  property p_read_byte;
    @(posedge aclk) disable iff (!aresetn || !core_rst_n)
      (state_reg == ST_TRD) |=> latch_reg == ($past(flash_addr_reg[0] ^ flash_addr_reg[0] ^ flash_addr_sel_reg) ?
        $past(flash_rdata[15:8]) : $past(flash_rdata[7:0]));
  endproperty
  a_read_byte: assert property (p_read_byte) else $error("latch does not hold the addressed byte");

  property p_postinc;
    @(posedge aclk) disable iff (!aresetn || !core_rst_n)
      (op_go && op_mode == PTR_POSTINC) |=> ptr_reg[20:0] == $past(ptr_reg[20:0]) + 21'h1;
  endproperty
  a_postinc: assert property (p_postinc) else $error("pointer not advanced after table op");

  property p_erase_block;
    @(posedge aclk) disable iff (!aresetn || !core_rst_n)
      flash_erase_en_reg |-> flash_addr_reg[8:0] == 9'h000 && cpu_stall_reg;
  endproperty
  a_erase_block: assert property (p_erase_block) else $error("erase not block aligned");

  property p_erase_start;
    @(posedge aclk) disable iff (!aresetn || !core_rst_n)
      (start_ok && erase_reg) |=> state_reg == ST_ERASE ##1 flash_erase_en_reg;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("valid start did not begin erase");

  property p_stall;
    @(posedge aclk) disable iff (!aresetn || !core_rst_n)
      long_busy |-> cpu_stall_reg;
  endproperty
  a_stall: assert property (p_stall) else $error("core not stalled during long write");

  property p_timer_bound;
    @(posedge aclk) disable iff (!aresetn || !core_rst_n)
      (state_reg == ST_TIMER) |-> timer_reg < TMR_W'(LONG_WRITE_CYCLES);
  endproperty
  a_timer_bound: assert property (p_timer_bound) else $error("long write overran its timer");

  property p_word_mode;
    @(posedge aclk) disable iff (!aresetn || !core_rst_n)
      (state_reg == ST_PROG && word_program_bit_reg) |=> state_reg == ST_TIMER && flash_prog_en_reg ##1 !flash_prog_en_reg;
  endproperty
  a_word_mode: assert property (p_word_mode) else $error("word mode programmed more than one word");

  property p_no_array_write;
    @(posedge aclk) disable iff (!aresetn || !core_rst_n)
      (state_reg == ST_IDLE) |-> !flash_prog_en_reg && !flash_erase_en_reg;
  endproperty
  a_no_array_write: assert property (p_no_array_write) else $error("array touched outside a long write");

  property p_start_clear;
    @(posedge aclk) disable iff (!aresetn || !core_rst_n)
      $fell(start_reg) |-> $past(state_reg) == ST_TIMER && !erase_reg;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start cleared before completion");

  property p_locked;
    @(posedge aclk) disable iff (!aresetn || !core_rst_n)
      (start_req && unlock_reg != UL_OPEN) |=> state_reg == ST_IDLE && err_reg && !start_reg;
  endproperty
  a_locked: assert property (p_locked) else $error("start taken without unlock");
endmodule

/* File: testbench/fsps_flash_model.sv */
`timescale 1ns/1ps
module fsps_flash_model (
  input wire logic aclk,
  input wire logic [20:0] flash_addr,
  input wire logic flash_rd_en,
  output logic [15:0] flash_rdata,
  input wire logic flash_prog_en,
  input wire logic [15:0] flash_wdata,
  input wire logic flash_erase_en
);
  logic [15:0] mem [int]; // sparse word store, absent reads as erased
  int prog_count = 0; // words programmed so far
  logic [15:0] held = 16'h0000; // word of the last read
  logic hold = 1'b0; // cycle after a read
  function automatic logic [15:0] look(input logic [20:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
  endfunction
  // array updates on the core clock
  always @(posedge aclk) begin
    hold <= flash_rd_en;
    if (flash_rd_en) held <= look(flash_addr);
    if (flash_prog_en) begin
      mem[int'(flash_addr)] = flash_wdata;
      prog_count++;
    end
    // whole 512-word block, low address bits ignored
    if (flash_erase_en) begin
      for (int i = 0; i < 512; i++) mem.delete(int'({flash_addr[20:9], 9'h000}) + i);
    end
  end
  // data valid in the read cycle and the next; otherwise inverted so stale data is never trusted
  always @(flash_rd_en or flash_addr or hold or held) begin
    if (flash_rd_en) flash_rdata = look(flash_addr);
    else if (hold) flash_rdata = held;
    else flash_rdata = ~held;
  end
endmodule

/* File: testbench/test_flash_self_program_sequencer.sv */
`timescale 1ns/1ps
module test_flash_self_program_sequencer;
  import fsps_pkg::*;
  localparam int LW = 20; // shortened long write
  localparam logic [31:0] ST = 32'h2; // start
  localparam logic [31:0] WE = 32'h4; // write enable
  localparam logic [31:0] EF = 32'h8; // error flag
  localparam logic [31:0] ES = 32'h10; // erase-select
  localparam logic [31:0] WP = 32'h20; // word program
  logic aclk, aresetn, core_rst_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [20:0] flash_addr;
  logic [15:0] flash_rdata, flash_wdata;
  logic flash_rd_en, flash_prog_en, flash_erase_en, cpu_stall;
  int bad_count, check_count;
  fsps_sequencer #(.LONG_WRITE_CYCLES(LW)) fsps_sequencer_inst (.aclk, .aresetn, .core_rst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_addr,
    .flash_rd_en, .flash_rdata, .flash_prog_en, .flash_wdata, .flash_erase_en, .cpu_stall);
  fsps_flash_model fsps_flash_model_inst (.aclk, .flash_addr, .flash_rd_en, .flash_rdata,
    .flash_prog_en, .flash_wdata, .flash_erase_en);
  // 50 MHz core clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one comparison, four-state exact
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  // sampled at the falling edge, which shows what the next rising edge will take
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic aw_t, w_t, b_t;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    b_t = 1'b0;
    for (int n = 0; n < 200 && !b_t; n++) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      if (b_t) chk("bresp", s_axi_bresp, er);
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    // a hung write ends the run
    if (!b_t) begin
      chk("bvalid", 0, 1);
      test_done();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm, input logic [1:0] er = 2'h0);
    logic a_t, r_t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    r_t = 1'b0;
    for (int n = 0; n < 200 && !r_t; n++) begin
      @(negedge aclk);
      a_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      if (r_t) chk("rresp", s_axi_rresp, er);
      if (r_t && er == RESP_OKAY) chk(nm, s_axi_rdata, exp);
      @(posedge aclk);
      if (a_t) s_axi_arvalid <= 1'b0;
    end
    if (!r_t) begin
      chk("rvalid", 0, 1);
      test_done();
    end
  endtask
  // unlock keys, start, then time the stall
  task automatic lw(input logic [31:0] c);
    int n;
    wr(OFS_CONTROL, c);
    wr(OFS_UNLOCK, 32'h55);
    wr(OFS_UNLOCK, 32'hAA);
    wr(OFS_CONTROL, c | ST);
    for (n = 0; n < 200; n++) begin
      @(negedge aclk);
      if (!cpu_stall) break;
    end
    @(posedge aclk);
    chk("stall", n >= LW && n < LW + 40, 1);
  endtask
  // one table write of a byte
  task automatic tw(input logic [7:0] d, input logic [4:0] op);
    wr(OFS_LATCH, {24'h0, d});
    wr(OFS_TABLE_OP, {27'h0, op});
  endtask
  function automatic logic [7:0] bv(input int i);
    return 8'(i) ^ 8'hA5;
  endfunction
  task automatic t_reset;
    rd(OFS_CONTROL, 0, "ctrl");
    rd(OFS_LATCH, LATCH_RESET, "latch");
    rd(OFS_POINTER, POINTER_RESET, "ptr");
    rd(OFS_UNLOCK, 0, "unlock");
    rd(8'h18, 0, "hole", RESP_SLVERR);
    wr(8'h1C, 1, RESP_SLVERR);
    $display("reset test done");
  endtask
  // table read with a pointer mode
  task automatic top(input fsps_ptr_mode_type m, input logic [7:0] l, input logic [31:0] p);
    wr(OFS_TABLE_OP, {30'h0, m});
    rd(OFS_LATCH, {24'h0, l}, "latch");
    rd(OFS_POINTER, p, "ptr");
  endtask
  task automatic t_read;
    fsps_flash_model_inst.mem[5] = 16'hBEEF;
    fsps_flash_model_inst.mem[6] = 16'h1234;
    wr(OFS_POINTER, 32'h0A);
    top(PTR_POSTINC, 8'hEF, 32'h0B);
    top(PTR_KEEP, 8'hBE, 32'h0B);
    top(PTR_PREINC, 8'h34, 32'h0C);
    top(PTR_POSTDEC, 8'h34, 32'h0B);
    $display("table read test done");
  endtask
  task automatic t_word;
    int pc;
    pc = fsps_flash_model_inst.prog_count;
    wr(OFS_POINTER, 32'h442);
    tw(8'h11, 5'h11);
    tw(8'h22, 5'h10);
    chk("short", fsps_flash_model_inst.prog_count, pc);
    lw(WE | WP);
    chk("word", fsps_flash_model_inst.mem[32'h221], 32'h2211);
    chk("count", fsps_flash_model_inst.prog_count, pc + 1);
    rd(OFS_CONTROL, WE | WP, "ctrl");
    $display("word program test done");
  endtask
  task automatic t_refuse;
    wr(OFS_CONTROL, WE | ST);
    rd(OFS_CONTROL, WE | EF, "ctrl");
    wr(OFS_UNLOCK, 32'h55);
    wr(OFS_LATCH, 0);
    wr(OFS_UNLOCK, 32'hAA);
    wr(OFS_CONTROL, WE | ST);
    chk("nostall", cpu_stall, 0);
    wr(OFS_CONTROL, 0);
    wr(OFS_UNLOCK, 32'h55);
    wr(OFS_UNLOCK, 32'hAA);
    rd(OFS_STATUS, 1, "status");
    wr(OFS_CONTROL, ST);
    rd(OFS_CONTROL, EF, "ctrl");
    $display("refusal test done");
  endtask
  task automatic t_block;
    int pc;
    pc = fsps_flash_model_inst.prog_count;
    wr(OFS_POINTER, 32'h800);
    for (int i = 0; i < 64; i++) tw(bv(i), 5'h11);
    wr(OFS_POINTER, 32'h800);
    lw(WE);
    chk("count", fsps_flash_model_inst.prog_count, pc + 32);
    for (int i = 0; i < 32; i++) chk("row", fsps_flash_model_inst.mem[32'h400 + i], {bv(2*i+1), bv(2*i)});
    rd(OFS_CONTROL, WE, "ctrl");
    wr(OFS_POINTER, 32'h886);
    lw(WE | WP);
    chk("kept", fsps_flash_model_inst.mem[32'h443], {bv(7), bv(6)});
    $display("block program test done");
  endtask
  task automatic t_erase;
    fsps_flash_model_inst.mem[32'h1FF] = 16'h0001;
    fsps_flash_model_inst.mem[32'h200] = 16'h0002;
    wr(OFS_POINTER, 32'h0A);
    lw(WE | ES);
    chk("gone", fsps_flash_model_inst.mem.exists(32'h1FF), 0);
    chk("gone", fsps_flash_model_inst.mem.exists(5), 0);
    chk("next", fsps_flash_model_inst.mem.exists(32'h200), 1);
    rd(OFS_CONTROL, WE, "ctrl");
    $display("erase test done");
  endtask
  task automatic t_abort;
    wr(OFS_CONTROL, WE | ES);
    wr(OFS_UNLOCK, 32'h55);
    wr(OFS_UNLOCK, 32'hAA);
    wr(OFS_CONTROL, WE | ES | ST);
    @(negedge aclk);
    chk("stall", cpu_stall, 1);
    @(posedge aclk);
    core_rst_n <= 1'b0;
    @(posedge aclk);
    core_rst_n <= 1'b1;
    @(negedge aclk);
    chk("stall", cpu_stall, 0);
    @(posedge aclk);
    rd(OFS_CONTROL, EF, "ctrl");
    $display("abort test done");
  endtask
  // main sequence
  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    // response ready held high throughout, so every answer is taken at its first edge
    {s_axi_bready, s_axi_rready} = 2'b11;
    core_rst_n = 1'b1;
    s_axi_wstrb = 4'hF;
    bad_count = 0;
    check_count = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_read();
    t_word();
    t_refuse();
    t_block();
    t_erase();
    t_abort();
    test_done();
  end
endmodule
